// File: src/clock_ctrl_defines.vh
// Purpose: offsets, field positions and reset values of the clock control
// Assumes: 32-bit APB, one register per aligned word
// Notes:   included by the clock control module only, not by pow2_divider
`ifndef CLOCK_CTRL_DEFINES_VH
`define CLOCK_CTRL_DEFINES_VH

// register byte offsets
`define OFS_OSC_CONTROL   12'h000
`define OFS_CLOCK_DIVIDER 12'h004
`define OFS_UNLOCK_KEY    12'h008
`define OFS_IRQ_STATUS    12'h00C
`define OFS_IRQ_MASK      12'h010

// unlock key words
`define UNLOCK_KEY_FIRST  8'h46
`define UNLOCK_KEY_SECOND 8'h57

// osc_control_reg fields
`define OSC_CUR_HI        14
`define OSC_CUR_LO        12
`define OSC_NEW_HI        10
`define OSC_NEW_LO        8
`define OSC_FAIL_BIT      3
`define OSC_SWITCH_BIT    0
`define OSC_NEW_RESET     3'h0
`define OSC_CUR_RESET     3'h0

// clock_divider_reg fields
`define DIV_ROI_BIT       15
`define DIV_DOZE_HI       14
`define DIV_DOZE_LO       12
`define DIV_REDUCE_RATIO_ENABLE_BIT     11
`define DIV_FRC_HI        10
`define DIV_FRC_LO        8
`define DIV_PRE_HI        3
`define DIV_PRE_LO        0
`define DIV_DOZE_RESET    3'h3
`define DIV_FRC_RESET     3'h0
`define DIV_PRE_RESET     4'h1

// interrupt status bits
`define IRQ_FAIL_BIT      0
`define IRQ_SWITCH_BIT    1
`define IRQ_RECOVER_BIT   2
`define IRQ_WIDTH         3

`endif

// File: src/clock_switch_and_divider_ctrl.v
// Purpose: oscillator switch and clock divider control behind APB
// Assumes: fail and switch-done inputs come from other clock domains
// Notes:   dividers deliver tick enables at the divided rates
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "clock_ctrl_defines.vh"

module clock_switch_and_divider_ctrl (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        monitor_fail,
    input  wire        switch_done,
    input  wire        cpu_interrupt,
    output wire [2:0]  new_source_select,
    output wire        switch_request,
    output reg         osc_fail_trap,
    output wire        periph_tick,
    output wire        fast_rc_tick,
    output wire        irq
);

    ////////////////////////////////////////////////////////////////////////
    // state

    reg  [2:0]  current_source;
    reg  [2:0]  new_source;
    reg         clock_fail_flag;
    reg         switch_req;
    reg         recover_on_irq;
    reg  [2:0]  doze_ratio;
    reg         reduce_ratio_enable;
    reg  [2:0]  fast_rc_postscale;
    reg  [3:0]  pll_input_divider;
    reg  [1:0]  unlock_state;
    reg  [`IRQ_WIDTH-1:0] irq_status;
    reg  [`IRQ_WIDTH-1:0] irq_mask;
    reg  [`IRQ_WIDTH-1:0] read_snapshot;

    localparam [1:0] UNLOCK_IDLE  = 2'd0;
    localparam [1:0] UNLOCK_HALF  = 2'd1;
    localparam [1:0] UNLOCK_ARMED = 2'd2;

    wire        setup_phase;
    wire        access_phase;
    wire        wr;
    wire        rd;
    wire        mapped;
    wire        fail_event;
    wire        done_event;
    wire        osc_write;
    wire        div_write;
    wire        sw_sets_fail;
    wire        recover_event;
    wire [2:0]  next_doze_ratio;
    wire [2:0]  effective_doze;
    wire [3:0]  frc_code;
    wire [1:0]  async_in;
    wire [1:0]  synced;
    wire [1:0]  synced_d1;
    wire [31:0] osc_word;
    wire [31:0] div_word;
    wire [`IRQ_WIDTH-1:0] irq_events;
    reg  [31:0] next_prdata;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign mapped = (paddr == `OFS_OSC_CONTROL) |
                    (paddr == `OFS_CLOCK_DIVIDER) |
                    (paddr == `OFS_UNLOCK_KEY) |
                    (paddr == `OFS_IRQ_STATUS) |
                    (paddr == `OFS_IRQ_MASK);
    assign pready  = 1'b1;
    assign pslverr = access_phase & ~mapped;
    assign wr = access_phase & pwrite & mapped;
    assign rd = access_phase & ~pwrite & mapped;

    assign osc_write = wr & (paddr == `OFS_OSC_CONTROL) &
                       (unlock_state == UNLOCK_ARMED);
    assign div_write = wr & (paddr == `OFS_CLOCK_DIVIDER);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers and edges

    assign async_in = {switch_done, monitor_fail};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            reg stage_one;
            reg stage_two;
            reg stage_prev;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage_one  <= 1'b0;
                    stage_two  <= 1'b0;
                    stage_prev <= 1'b0;
                end else begin
                    stage_one  <= async_in[gi];
                    stage_two  <= stage_one;
                    stage_prev <= stage_two;
                end
            end
            assign synced[gi]    = stage_two;
            assign synced_d1[gi] = stage_prev;
        end
    endgenerate

    assign fail_event    = synced[0] & ~synced_d1[0];
    assign done_event    = synced[1] & ~synced_d1[1] & switch_req;
    assign sw_sets_fail  = osc_write & pwdata[`OSC_FAIL_BIT];
    assign recover_event = recover_on_irq & cpu_interrupt &
                           reduce_ratio_enable;

    ////////////////////////////////////////////////////////////////////////
    // unlock sequence

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_state <= UNLOCK_IDLE;
        end else if (wr & (paddr == `OFS_UNLOCK_KEY)) begin
            case (unlock_state)
                UNLOCK_IDLE: begin
                    if (pwdata[7:0] == `UNLOCK_KEY_FIRST)
                        unlock_state <= UNLOCK_HALF;
                end
                UNLOCK_HALF: begin
                    if (pwdata[7:0] == `UNLOCK_KEY_SECOND)
                        unlock_state <= UNLOCK_ARMED;
                    else
                        unlock_state <= UNLOCK_IDLE;
                end
                default: begin
                    unlock_state <= UNLOCK_IDLE;
                end
            endcase
        end else if (wr & (paddr == `OFS_OSC_CONTROL)) begin
            unlock_state <= UNLOCK_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator control

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_source      <= `OSC_NEW_RESET;
            current_source  <= `OSC_CUR_RESET;
            clock_fail_flag <= 1'b0;
            switch_req      <= 1'b0;
            osc_fail_trap   <= 1'b0;
        end else begin
            osc_fail_trap <= fail_event | sw_sets_fail;
            if (osc_write)
                new_source <= pwdata[`OSC_NEW_HI:`OSC_NEW_LO];
            if (fail_event | sw_sets_fail)
                clock_fail_flag <= 1'b1;
            else if (osc_write)
                clock_fail_flag <= 1'b0;
            if (osc_write & pwdata[`OSC_SWITCH_BIT])
                switch_req <= 1'b1;
            else if (done_event)
                switch_req <= 1'b0;
            if (done_event)
                current_source <= new_source;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock divider control

    assign next_doze_ratio = (div_write & ~reduce_ratio_enable) ?
                             pwdata[`DIV_DOZE_HI:`DIV_DOZE_LO] :
                             doze_ratio;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recover_on_irq      <= 1'b0;
            doze_ratio          <= `DIV_DOZE_RESET;
            reduce_ratio_enable <= 1'b0;
            fast_rc_postscale   <= `DIV_FRC_RESET;
            pll_input_divider   <= `DIV_PRE_RESET;
        end else begin
            doze_ratio <= next_doze_ratio;
            if (div_write) begin
                recover_on_irq    <= pwdata[`DIV_ROI_BIT];
                fast_rc_postscale <= pwdata[`DIV_FRC_HI:`DIV_FRC_LO];
                pll_input_divider <= pwdata[`DIV_PRE_HI:`DIV_PRE_LO];
            end
            if (recover_event)
                reduce_ratio_enable <= 1'b0;
            else if (div_write & ~pwdata[`DIV_REDUCE_RATIO_ENABLE_BIT])
                reduce_ratio_enable <= 1'b0;
            else if (div_write & (next_doze_ratio != 3'h0))
                reduce_ratio_enable <= 1'b1;
        end
    end

    assign effective_doze = reduce_ratio_enable ? doze_ratio : 3'h0;

    pow2_divider #(
        .CODE_W (3),
        .CNT_W  (8)
    ) u_doze_div (
        .pclk    (pclk),
        .presetn (presetn),
        .code    (effective_doze),
        .tick    (periph_tick)
    );

    // top postscale code skips a power: it divides by 256
    assign frc_code = (fast_rc_postscale == 3'h7) ? 4'h8 :
                      {1'b0, fast_rc_postscale};

    pow2_divider #(
        .CODE_W (4),
        .CNT_W  (9)
    ) u_frc_div (
        .pclk    (pclk),
        .presetn (presetn),
        .code    (frc_code),
        .tick    (fast_rc_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupts

    assign irq_events = {recover_event, done_event, fail_event | sw_sets_fail};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= {`IRQ_WIDTH{1'b0}};
            irq_mask   <= {`IRQ_WIDTH{1'b0}};
        end else begin
            if (rd & (paddr == `OFS_IRQ_STATUS))
                irq_status <= (irq_status & ~read_snapshot) | irq_events;
            else
                irq_status <= irq_status | irq_events;
            if (wr & (paddr == `OFS_IRQ_MASK))
                irq_mask <= pwdata[`IRQ_WIDTH-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup phase

    assign osc_word = {17'h00000, current_source, 1'b0, new_source,
                       4'h0, clock_fail_flag, 2'b00, switch_req};
    assign div_word = {16'h0000, recover_on_irq, doze_ratio,
                       reduce_ratio_enable, fast_rc_postscale,
                       4'h0, pll_input_divider};

    always @* begin
        next_prdata = 32'h00000000;
        case (paddr)
            `OFS_OSC_CONTROL:   next_prdata = osc_word;
            `OFS_CLOCK_DIVIDER: next_prdata = div_word;
            `OFS_IRQ_STATUS:    next_prdata = {29'h00000000, irq_status};
            `OFS_IRQ_MASK:      next_prdata = {29'h00000000, irq_mask};
            default:            next_prdata = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata        <= 32'h00000000;
            read_snapshot <= {`IRQ_WIDTH{1'b0}};
        end else if (setup_phase) begin
            prdata        <= next_prdata;
            read_snapshot <= irq_status;
        end
    end

    assign new_source_select = new_source;
    assign switch_request    = switch_req;

endmodule

// File: src/pow2_divider.v
// Purpose: tick generator dividing the clock by two to the power of a code
// Assumes: code may change at any time; counter restarts cleanly
// Notes:   code 0 gives a tick on every cycle
`timescale 1ns/1ps

module pow2_divider #(
    parameter CODE_W = 3,
    parameter CNT_W  = 8
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire [CODE_W-1:0] code,
    output reg               tick
);

    reg  [CNT_W-1:0] count;
    wire [CNT_W-1:0] limit;

    // terminal count is 2^code - 1
    assign limit = ({{(CNT_W-1){1'b0}}, 1'b1} << code) - {{(CNT_W-1){1'b0}}, 1'b1};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= {CNT_W{1'b0}};
            tick  <= 1'b0;
        end else if (count >= limit) begin
            count <= {CNT_W{1'b0}};
            tick  <= 1'b1;
        end else begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
    end

endmodule

// File: test/clock_ctrl_sva.sv
// Purpose: port checks for the clock control
// Assumes: zero wait APB, synced async inputs
// Notes:   bound onto the top module
`timescale 1ns/1ps
module clock_ctrl_sva (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        monitor_fail,
    input logic        switch_done,
    input logic        cpu_interrupt,
    input logic [2:0]  new_source_select,
    input logic        switch_request,
    input logic        osc_fail_trap,
    input logic        periph_tick,
    input logic        fast_rc_tick,
    input logic        irq
);
    logic [9:0] frc_gap;
    logic [9:0] per_gap;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frc_gap <= 10'h000;
            per_gap <= 10'h000;
        end else begin
            frc_gap <= fast_rc_tick ? 10'h000 : frc_gap + 10'h001;
            per_gap <= periph_tick ? 10'h000 : per_gap + 10'h001;
        end
    end
    a_fail_trap: assert property (
        $rose(monitor_fail) |-> ##[1:5] osc_fail_trap)
        else $error("no trap after monitor failure");
    a_trap_pulse: assert property (
        osc_fail_trap |=> !osc_fail_trap)
        else $error("trap longer than one cycle");
    a_switch_clear: assert property (
        $rose(switch_done) && switch_request |-> ##[1:5] !switch_request)
        else $error("switch request not cleared");
    a_switch_cause: assert property (
        $fell(switch_request) |-> $past(switch_done, 3))
        else $error("switch request fell without done");
    a_osc_zero: assert property (
        psel && penable && !pwrite && paddr[11:2] == 10'h000
        |-> prdata[2:1] == 2'h0 && prdata[31:15] == 17'h00000)
        else $error("unused oscillator bits not zero");
    a_frc_gap: assert property (
        frc_gap < 10'h100)
        else $error("fast rc tick gap too long");
    a_per_gap: assert property (
        per_gap < 10'h080)
        else $error("peripheral tick gap too long");
    a_bad_addr: assert property (
        psel && penable && paddr[11:2] > 10'h004
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    c_switch: cover property ($fell(switch_request));
    c_trap: cover property (osc_fail_trap);
    c_err: cover property (pslverr);
endmodule

bind clock_switch_and_divider_ctrl clock_ctrl_sva u_clock_ctrl_sva (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .monitor_fail, .switch_done, .cpu_interrupt,
    .new_source_select, .switch_request, .osc_fail_trap, .periph_tick,
    .fast_rc_tick, .irq);

// File: test/testbench.sv
// Purpose: register level test of the clock control
// Assumes: zero wait APB slave
// Notes:   self checking, ends with a verdict
`timescale 1ns/1ps
module testbench;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic        monitor_fail = 0;
    logic        switch_done = 0;
    logic        cpu_interrupt = 0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, switch_request, osc_fail_trap;
    logic        periph_tick, fast_rc_tick, irq;
    logic [2:0]  new_source_select;
    int          n_errors = 0;
    int          n_compared = 0;
    int          traps = 0;
    int          cyc = 0;
    int          n, i;
    clock_switch_and_divider_ctrl u_clock_switch_and_divider_ctrl (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .monitor_fail, .switch_done, .cpu_interrupt,
        .new_source_select, .switch_request, .osc_fail_trap, .periph_tick,
        .fast_rc_tick, .irq);
    ////////////////////////////////////////
    initial forever #25 pclk = ~pclk;
    task test_done;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task unlock;
        wr(12'h008, 32'h46);
        wr(12'h008, 32'h57);
    endtask
    task gap(input logic s);
        repeat (3) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while ((s ? fast_rc_tick : periph_tick) !== 1'b1);
        end
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (osc_fail_trap === 1'b1) traps <= traps + 1;
        if (cyc == 20000) begin
            n_errors++;
            test_done;
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h000, 32'h0);
        rdc(12'h004, 32'h3001);
        wr(12'h010, 32'h7);
        rdc(12'h010, 32'h7);
        wr(12'h000, 32'h0501);
        rdc(12'h000, 32'h0);
        unlock;
        wr(12'h000, 32'h0501);
        rdc(12'h000, 32'h0501);
        chk("select", 32'h5, {29'h0, new_source_select});
        switch_done <= 1'b1;
        repeat (6) @(posedge pclk);
        rdc(12'h000, 32'h5500);
        wr(12'h008, 32'h46);
        wr(12'h008, 32'h12);
        wr(12'h000, 32'h0601);
        rdc(12'h000, 32'h5500);
        switch_done <= 1'b0;
        monitor_fail <= 1'b1;
        repeat (6) @(posedge pclk);
        rdc(12'h000, 32'h5508);
        chk("irq", 32'h1, {31'h0, irq});
        rdc(12'h00C, 32'h3);
        @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        unlock;
        wr(12'h000, 32'h0500);
        rdc(12'h000, 32'h5500);
        unlock;
        wr(12'h000, 32'h0508);
        rdc(12'h000, 32'h5508);
        chk("traps", 32'h2, traps);
        monitor_fail <= 1'b0;
        wr(12'h004, 32'h0801);
        rdc(12'h004, 32'h0001);
        wr(12'h004, 32'hA801);
        rdc(12'h004, 32'hA801);
        gap(1'b0);
        chk("ratio gap", 32'h4, n);
        wr(12'h004, 32'hF801);
        rdc(12'h004, 32'hA801);
        cpu_interrupt <= 1'b1;
        @(posedge pclk);
        cpu_interrupt <= 1'b0;
        rdc(12'h004, 32'hA001);
        rdc(12'h00C, 32'h5);
        gap(1'b0);
        chk("ratio gap", 32'h1, n);
        for (i = 0; i < 8; i++) begin
            wr(12'h004, 32'hA001 | (i << 8));
            gap(1'b1);
            chk("frc gap", (i == 7) ? 32'h100 : 32'h1 << i, n);
        end
        xfer(1'b0, 12'h014, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        chk("bad data", 32'h0, rd);
        test_done;
    end
endmodule
